// File: slps_settings.sv
// settings and enable register bank of the serial link peripheral
// assumes an AHB-Lite master on hclk and units that sample the outputs
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "slps_params.svh"
module slps_settings #(
	parameter int                 NUM_BLOCKS      = 10,
	parameter int                 NUM_MCAST       = 8,
	parameter logic [15:0]        DEVICE_ID_RESET = 16'hFFFF
) (
	// clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic [31:0]                   hrdata,
	output logic                          hresp,
	// byte swapping
	output logic [3:0]                    memory_access_swap_bytes,
	output logic [3:0]                    load_store_swap_bytes,
	output logic [3:0]                    tx_rx_unit_swap_bytes,
	// destination filter
	input  wire logic                     rx_dest_valid,
	input  wire slps_pkg::slps_id_type    rx_dest_id,
	input  wire slps_pkg::slps_id_type    alt_device_id,
	input  wire logic [NUM_MCAST*16-1:0]  multicast_ids,
	output logic                          rx_dest_checked,
	output logic                          rx_dest_accept,
	// boot and physical layer start
	output logic                          phy_init_start,
	output logic                          phy_init_enable,
	// responses
	input  wire logic                     rsp_valid,
	input  wire slps_pkg::slps_prio_type  req_prio,
	input  wire slps_pkg::slps_prio_type  rsp_auto_prio,
	input  wire logic                     req_crf,
	output logic                          rsp_out_valid,
	output slps_pkg::slps_prio_type       rsp_prio,
	output logic                          rsp_crf,
	// transmit credit
	input  wire slps_pkg::slps_prio_type  tx_pkt_prio,
	input  wire logic [3:0]               tx_free_buffers,
	output logic                          tx_send_allowed,
	// bus priority and timer tick
	output logic [2:0]                    bus_priority,
	output logic                          timer_tick,
	// lanes
	input  wire slps_pkg::slps_lane_type  phy_lane_tx_enable,
	input  wire slps_pkg::slps_lane_type  phy_lane_rx_enable,
	output slps_pkg::slps_lane_type       lane_tx_enable,
	output slps_pkg::slps_lane_type       lane_rx_enable,
	output slps_pkg::slps_lane_type       lane_loopback,
	// retry
	input  wire logic                     retry_start,
	input  wire logic                     retry_timer_expired,
	output logic                          retry_discard,
	// core clock source
	output logic                          bus_clock_as_core_clock,
	output logic [1:0]                    core_clock_lane_select,
	// receive context
	input  wire logic [7:0]               rx_cos,
	output logic [7:0]                    rx_context_cos,
	input  wire logic [3:0]               ctx_free_count,
	input  wire slps_pkg::slps_prio_type  ctx_req_prio,
	output logic                          ctx_alloc_ok,
	// enables
	output logic                          peripheral_reset_n,
	output logic [NUM_BLOCKS-1:0]         block_reset_n
);
	import slps_pkg::*;

	// =====================================================
	// bus slave
	slps_bus_state_type state;
	logic [7:0]  addr_q;
	logic        wr_q;
	logic        sel;
	logic [31:0] rd_mux;

	// registers
	logic [31:0]           settings;
	logic [31:0]           settings_one;
	slps_id_type           primary_device_id;
	logic                  global_enable_bit;
	logic                  global_run;
	logic [NUM_BLOCKS-1:0] block_enable_bit;
	logic [NUM_BLOCKS-1:0] block_run;
	logic                  boot_q;
	logic [5:0]            retry_count;
	logic [5:0]            retry_target;
	logic [NUM_MCAST-1:0]  mcast_hit;

	wire boot_done = settings[`SLPS_F_BOOT_DONE];

	assign sel       = hsel & htrans[1] & hready;
	assign hreadyout = (state != SLPS_BUS_RDWAIT);
	assign hresp     = 1'b0;  // every access answers OKAY

	// address phase capture; reads take one wait state so hrdata is a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state  <= SLPS_BUS_IDLE;
			addr_q <= 8'h00;
			wr_q   <= 1'b0;
		end else begin
			wr_q <= sel & hwrite;
			if (sel) begin
				addr_q <= haddr[7:0];
			end
			unique case (state)
				SLPS_BUS_IDLE: begin
					if (sel && !hwrite) begin
						state <= SLPS_BUS_RDWAIT;
					end
				end
				SLPS_BUS_RDWAIT: begin
					state <= SLPS_BUS_IDLE;
				end
			endcase
		end
	end

	// read data loaded in the wait cycle, after any write just ahead of it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (state == SLPS_BUS_RDWAIT) begin
			hrdata <= rd_mux;
		end
	end

	// read mux; unmapped offsets read zero
	// reserved bits zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_q)
			`SLPS_OFF_SETTINGS:     rd_mux = settings;
			`SLPS_OFF_SETTINGS_ONE: rd_mux = settings_one;
			`SLPS_OFF_DEVICE_ID:    rd_mux = {16'h0000, primary_device_id};
			`SLPS_OFF_GLOBAL_EN:    rd_mux = {31'h0, global_enable_bit};
			// block state also in global view
			`SLPS_OFF_GLOBAL_STATE: rd_mux = 32'({block_run, global_run});
			default:                rd_mux = 32'h0000_0000;
		endcase
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			if (addr_q == 8'(`SLPS_OFF_BLOCK_EN + 4 * i)) begin
				rd_mux = {31'h0, block_enable_bit[i]};
			end
			if (addr_q == 8'(`SLPS_OFF_BLOCK_STATE + 4 * i)) begin
				rd_mux = {31'h0, block_run[i]};
			end
		end
	end

	// =====================================================
	// settings registers
	// writes masked, boot-done sticky until reset
	// boot-done set once, never cleared by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settings <= `SLPS_SET_RESET;
		end else if (wr_q && addr_q == `SLPS_OFF_SETTINGS) begin
			settings <= (hwdata & `SLPS_SET_MASK) | (settings & (32'h1 << `SLPS_F_BOOT_DONE));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settings_one <= `SLPS_SET1_RESET;
		end else if (wr_q && addr_q == `SLPS_OFF_SETTINGS_ONE) begin
			settings_one <= hwdata & `SLPS_SET1_MASK;
		end
	end

	// application-defined primary_device_id, read-only once boot is done
	// write lock after boot-done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			primary_device_id <= DEVICE_ID_RESET;
		end else if (wr_q && addr_q == `SLPS_OFF_DEVICE_ID && !boot_done) begin
			primary_device_id <= hwdata[15:0];
		end
	end

	// =====================================================
	// global and block enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_enable_bit <= `SLPS_EN_RESET;
		end else if (wr_q && addr_q == `SLPS_OFF_GLOBAL_EN) begin
			global_enable_bit <= hwdata[0];
		end
	end

	// global enable joined with module reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_run <= 1'b0;
		end else begin
			global_run <= global_enable_bit;
		end
	end
	assign peripheral_reset_n = global_run;

	genvar b;
	generate
		for (b = 0; b < NUM_BLOCKS; b++) begin : g_block
			// per-block enable bit
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					block_enable_bit[b] <= `SLPS_EN_RESET;
				end else if (wr_q && addr_q == 8'(`SLPS_OFF_BLOCK_EN + 4 * b)) begin
					block_enable_bit[b] <= hwdata[0];
				end
			end
			// held in reset while either enable is clear
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					block_run[b] <= 1'b0;
				end else begin
					block_run[b] <= global_enable_bit & block_enable_bit[b];
				end
			end
		end
	endgenerate
	// state bits read the very flops that drive the block resets
	assign block_reset_n = block_run;

	// =====================================================
	// static configuration outputs
	// swap size 1 shifted by code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			memory_access_swap_bytes <= 4'h1;
			load_store_swap_bytes    <= 4'h1;
			tx_rx_unit_swap_bytes    <= 4'h1;
		end else begin
			memory_access_swap_bytes <= 4'h1 << settings[`SLPS_F_MAU_SWAP +: 2];
			load_store_swap_bytes    <= 4'h1 << settings[`SLPS_F_LSU_SWAP +: 2];
			tx_rx_unit_swap_bytes    <= 4'h1 << settings[`SLPS_F_TXRX_SWAP +: 2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_priority            <= 3'h4;
			bus_clock_as_core_clock <= 1'b0;
			core_clock_lane_select  <= 2'h0;
			lane_loopback           <= 4'h0;
		end else begin
			bus_priority            <= settings[`SLPS_F_BUS_PRIO +: 3];
			bus_clock_as_core_clock <= settings_one[`SLPS_F_BUS_CLK];
			core_clock_lane_select  <= settings_one[`SLPS_F_CLK_LANE +: 2];
			lane_loopback           <= settings_one[`SLPS_F_LOOPBACK +: 4];
		end
	end

	// overridden lanes are held enabled for the pattern generator
	// lane enables taken from the physical layer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lane_tx_enable <= 4'h0;
			lane_rx_enable <= 4'h0;
		end else begin
			lane_tx_enable <= phy_lane_tx_enable | settings[`SLPS_F_PRBS_OVR +: 4];
			lane_rx_enable <= phy_lane_rx_enable | settings[`SLPS_F_PRBS_OVR +: 4];
		end
	end

	// =====================================================
	// boot-done edge starts physical layer bring-up
	// start on rising boot-done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_q         <= 1'b0;
			phy_init_start <= 1'b0;
		end else begin
			boot_q         <= boot_done;
			phy_init_start <= boot_done & ~boot_q;
		end
	end
	assign phy_init_enable = boot_q;

	// =====================================================
	// destination ID filter, answer one cycle after rx_dest_valid
	generate
		for (b = 0; b < NUM_MCAST; b++) begin : g_mcast
			assign mcast_hit[b] = (rx_dest_id == multicast_ids[b*16 +: 16]);
		end
	endgenerate

	// accept on match or when filter disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_dest_checked <= 1'b0;
			rx_dest_accept  <= 1'b0;
		end else begin
			rx_dest_checked <= rx_dest_valid;
			rx_dest_accept  <= rx_dest_valid & (settings[`SLPS_F_ID_FILTER_DIS]
				| rx_dest_id == primary_device_id | rx_dest_id == alt_device_id
				| (|mcast_hit));
		end
	end

	// =====================================================
	// response priority and critical flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsp_out_valid <= 1'b0;
			rsp_prio      <= 2'h0;
			rsp_crf       <= 1'b0;
		end else begin
			rsp_out_valid <= rsp_valid;
			if (rsp_valid) begin
				// fixed plus one when promotion disabled, saturates at 3
				if (settings[`SLPS_F_PROMO_DIS]) begin
					rsp_prio <= (req_prio == 2'h3) ? 2'h3 : req_prio + 2'h1;
				end else begin
					rsp_prio <= rsp_auto_prio;
				end
				rsp_crf <= req_crf | settings_one[`SLPS_F_CRF_FORCE];
			end
		end
	end

	// =====================================================
	// transmit credit check; priority 3 needs one free buffer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_send_allowed <= 1'b0;
		end else begin
			unique case (tx_pkt_prio)
				2'h2: tx_send_allowed <= tx_free_buffers >= {1'b0, settings[`SLPS_F_PRIO2_THR +: 3]} + 4'h1;
				2'h1: tx_send_allowed <= tx_free_buffers >= {1'b0, settings[`SLPS_F_PRIO1_THR +: 3]} + 4'h1;
				2'h0: tx_send_allowed <= tx_free_buffers >= {1'b0, settings[`SLPS_F_PRIO0_THR +: 3]} + 4'h1;
				2'h3: tx_send_allowed <= tx_free_buffers != 4'h0;
			endcase
		end
	end

	// =====================================================
	// prescaled tick, stopped while the peripheral is disabled
	slps_tick_div u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.enable  (global_run),
		.reload  (settings[`SLPS_F_PRESCALE +: 4]),
		.tick    (timer_tick)
	);

	// =====================================================
	// retry expiry counter; reserved codes behave as 32
	always_comb begin
		retry_target = 6'h20;
		if (settings_one[`SLPS_F_RETRY_DEPTH +: 4] < 4'h6) begin
			retry_target = 6'h01 << settings_one[`SLPS_F_RETRY_DEPTH +: 3];
		end
	end

	// discard after the chosen number of expiries
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			retry_count   <= 6'h00;
			retry_discard <= 1'b0;
		end else begin
			retry_discard <= 1'b0;
			if (retry_start) begin
				retry_count <= 6'h00;
			end else if (retry_timer_expired) begin
				if (retry_count + 6'h01 >= retry_target) begin
					retry_count   <= 6'h00;
					retry_discard <= 1'b1;
				end else begin
					retry_count <= retry_count + 6'h01;
				end
			end
		end
	end

	// =====================================================
	// receive context key and watermark
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_context_cos <= 8'h00;
			ctx_alloc_ok   <= 1'b0;
		end else begin
			// class of service in context key
			rx_context_cos <= settings_one[`SLPS_F_CLASS_OF_SERVICE_CONTEXT_ENABLE] ? rx_cos : 8'h00;
			if (settings_one[`SLPS_F_WATERMARK]) begin
				ctx_alloc_ok <= (ctx_free_count > 4'h2)
					| (ctx_free_count == 4'h2 && (ctx_req_prio == 2'h1 || ctx_req_prio == 2'h2))
					| (ctx_free_count == 4'h1 && ctx_req_prio == 2'h2);
			end else begin
				ctx_alloc_ok <= ctx_free_count != 4'h0;
			end
		end
	end

	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, haddr[31:8]};
endmodule // slps_settings
`default_nettype wire

// File: slps_params.svh
// register map, field positions and reset values of the link settings bank
// assumes AHB-Lite word access, byte offsets in the low address byte
//
// Functional notes
// - Two-bit swap codes 0..3 pick 1, 2, 4 or 8 byte swapping per unit.
// - Filter on: accept base, device or multicast IDs only; off: all.
// - All registers but the state ones writable before boot-done; locked ones ignore writes after.
// - Software sets boot-done once; its rise starts physical layer bring-up.
// - Promotion off: response at request priority plus one; on: automatic.
// - Priority 2 sends only with code+1 or more free buffers, reset 1.
// - Priority 1 sends only with at least code+1 free buffers, reset 2.
// - Priority 0 sends only with at least code+1 free buffers, reset 3.
// - Three-bit bus priority, 0 highest, 7 lowest, reset 4.
// - Prescaler reload divides bus clock by 1 to 16 for response timers.
// - Per-lane override takes lane enables away from the physical layer.
// - Pending retry dropped after 1,2,4,8,16,32 timer expiries for codes 0..5.
// - Bus-clock bit set makes the bus clock the core clock source.
// - Lane select 0..3 picks the transmit lane clocking the core.
// - Class-of-service enable adds the value to the receive context key.
// - Each loopback bit turns that lane's transmit data back digitally.
// - Watermark on: allocate if >2 free, 2 free prio 1-2, 1 free prio 2.
// - Response critical flag copies request, or is forced to one.
// - Global enable combines with module reset and feeds every block.
// - Cleared enables hold a block in reset; status shows it.
// - Block state readable in its own register and in the global one.
`ifndef SLPS_PARAMS_SVH
`define SLPS_PARAMS_SVH

// register offsets
`define SLPS_OFF_SETTINGS     8'h14
`define SLPS_OFF_SETTINGS_ONE 8'h18
`define SLPS_OFF_DEVICE_ID    8'h1C
`define SLPS_OFF_GLOBAL_EN    8'h20
`define SLPS_OFF_GLOBAL_STATE 8'h24
`define SLPS_OFF_BLOCK_EN     8'h40
`define SLPS_OFF_BLOCK_STATE  8'h80

// writable masks and reset values
`define SLPS_SET_MASK         32'hF9FFFEFF
`define SLPS_SET_RESET        32'h00053800
`define SLPS_SET1_MASK        32'h0000F3FF
`define SLPS_SET1_RESET       32'h00000000
`define SLPS_EN_RESET         1'b1

// settings field positions (low bit)
`define SLPS_F_MAU_SWAP       30
`define SLPS_F_LSU_SWAP       28
`define SLPS_F_ID_FILTER_DIS  27
`define SLPS_F_BOOT_DONE      24
`define SLPS_F_TXRX_SWAP      22
`define SLPS_F_PROMO_DIS      21
`define SLPS_F_PRIO2_THR      18
`define SLPS_F_PRIO1_THR      15
`define SLPS_F_PRIO0_THR      12
`define SLPS_F_BUS_PRIO       9
`define SLPS_F_PRESCALE       4
`define SLPS_F_PRBS_OVR       0

// settings one field positions (low bit)
`define SLPS_F_RETRY_DEPTH    12
`define SLPS_F_BUS_CLK        9
`define SLPS_F_CLASS_OF_SERVICE_CONTEXT_ENABLE         8
`define SLPS_F_LOOPBACK       4
`define SLPS_F_CLK_LANE       2
`define SLPS_F_WATERMARK      1
`define SLPS_F_CRF_FORCE      0

`endif

// File: slps_pkg.sv
// shared types of the link settings bank
// assumes nothing beyond a SystemVerilog compiler
package slps_pkg;
	// bus slave states, gray along idle -> read wait
	typedef enum logic [0:0] {
		SLPS_BUS_IDLE   = 1'b0,
		SLPS_BUS_RDWAIT = 1'b1
	} slps_bus_state_type;
	typedef logic [1:0] slps_prio_type;
	typedef logic [3:0] slps_lane_type;
	typedef logic [15:0] slps_id_type;
endpackage

// File: slps_tick_div.sv
// timer tick divider for the request-to-response timers
// assumes one clock; tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module slps_tick_div (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// control
	input  wire logic       enable,
	input  wire logic [3:0] reload,
	// tick out
	output logic            tick
);
	logic [3:0] count;

	// =====================================================
	// down counter, reloads so the period is reload+1 cycles
	// divide by one to sixteen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 4'h0;
			tick  <= 1'b0;
		end else if (!enable) begin
			count <= reload;  // held while the block is disabled
			tick  <= 1'b0;
		end else if (count == 4'h0) begin
			count <= reload;
			tick  <= 1'b1;
		end else begin
			count <= count - 4'h1;
			tick  <= 1'b0;
		end
	end
endmodule // slps_tick_div
`default_nettype wire

// File: slps_settings_asserts.sv
// checker for the link settings bank, watching only its top-level ports
// assumes one clock hclk, async active-low hresetn, hready tied to hreadyout
`timescale 1ns/1ps
`default_nettype none
// ==============================
// checker module
module slps_settings_asserts #(
	parameter int NUM_BLOCKS = 10
) (
	// clock and reset
	input wire logic                    hclk,
	input wire logic                    hresetn,
	// bus
	input wire logic                    hsel,
	input wire logic [1:0]              htrans,
	input wire logic                    hwrite,
	input wire logic                    hready,
	input wire logic                    hreadyout,
	// unit side
	input wire logic [3:0]              memory_access_swap_bytes,
	input wire logic                    rx_dest_valid,
	input wire logic                    rx_dest_checked,
	input wire logic                    rx_dest_accept,
	input wire logic                    phy_init_start,
	input wire logic                    phy_init_enable,
	input wire logic                    rsp_valid,
	input wire logic                    rsp_out_valid,
	input wire logic [3:0]              tx_free_buffers,
	input wire logic                    tx_send_allowed,
	input wire slps_pkg::slps_lane_type phy_lane_tx_enable,
	input wire slps_pkg::slps_lane_type lane_tx_enable,
	input wire logic [3:0]              ctx_free_count,
	input wire logic                    ctx_alloc_ok,
	input wire logic                    peripheral_reset_n,
	input wire logic [NUM_BLOCKS-1:0]   block_reset_n
);
	import slps_pkg::*;
	// everything is one domain, so clock and reset are given once
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// a read costs exactly one wait state
	a_read_wait: assert property ((hsel && htrans[1] && hready && !hwrite)
		|=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_swap_onehot: assert property ($onehot(memory_access_swap_bytes))
		else $error("swap size not a power of two");
	a_dest_answer: assert property (rx_dest_valid |=> rx_dest_checked)
		else $error("destination check missing");
	a_accept_qualified: assert property (rx_dest_accept |-> rx_dest_checked)
		else $error("accept without check");
	a_init_pulse: assert property (phy_init_start |=> !phy_init_start && phy_init_enable)
		else $error("init start not a single pulse");
	a_init_cause: assert property ($rose(phy_init_enable) |-> phy_init_start)
		else $error("init enable rose without start");
	a_rsp_answer: assert property (rsp_valid |=> rsp_out_valid)
		else $error("response not answered");
	a_no_credit: assert property (tx_free_buffers == 4'h0 |=> !tx_send_allowed)
		else $error("send allowed with no buffer");
	a_full_credit: assert property (tx_free_buffers == 4'h8 |=> tx_send_allowed)
		else $error("send refused with all buffers");
	a_prbs_keep: assert property (1'b1 |=>
		(lane_tx_enable & $past(phy_lane_tx_enable)) == $past(phy_lane_tx_enable))
		else $error("lane enable lost");
	a_ctx_empty: assert property (ctx_free_count == 4'h0 |=> !ctx_alloc_ok)
		else $error("context granted with none free");
	a_ctx_plenty: assert property (ctx_free_count > 4'h2 |=> ctx_alloc_ok)
		else $error("context refused with plenty free");
	a_block_global: assert property (block_reset_n != '0 |-> peripheral_reset_n)
		else $error("block running while peripheral held");
endmodule // slps_settings_asserts

bind slps_settings slps_settings_asserts #(.NUM_BLOCKS(NUM_BLOCKS)) u_slps_settings_asserts (.*);
`default_nettype wire

// File: tb.sv
// self-checking bench for the link settings bank
// assumes only AHB-Lite timing; every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module tb;
	import slps_pkg::*;
	// ==============================
	// stimulus and observed signals
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_crf = 1'b0;
	logic rx_dest_valid = 1'b0, rsp_valid = 1'b0, retry_start = 1'b0, retry_timer_expired = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
	slps_id_type rx_dest_id = 16'h0, alt_device_id = 16'h0042;
	logic [127:0] multicast_ids = {16'h0777, {7{16'h0ABC}}};
	slps_prio_type req_prio = 2'h0, rsp_auto_prio = 2'h0, tx_pkt_prio = 2'h0, ctx_req_prio = 2'h0;
	logic [3:0]  tx_free_buffers = 4'h0, ctx_free_count = 4'h0;
	slps_lane_type phy_lane_tx_enable = 4'h0, phy_lane_rx_enable = 4'h0;
	logic [7:0]  rx_cos = 8'h0, rx_context_cos;
	logic hreadyout, hresp, rx_dest_checked, rx_dest_accept, phy_init_start, phy_init_enable;
	logic rsp_out_valid, rsp_crf, tx_send_allowed, timer_tick, retry_discard;
	logic bus_clock_as_core_clock, ctx_alloc_ok, peripheral_reset_n;
	logic [31:0] hrdata;
	logic [3:0]  memory_access_swap_bytes, load_store_swap_bytes, tx_rx_unit_swap_bytes;
	logic [2:0]  bus_priority;
	logic [1:0]  core_clock_lane_select;
	logic [9:0]  block_reset_n;
	slps_prio_type rsp_prio;
	slps_lane_type lane_tx_enable, lane_rx_enable, lane_loopback;
	wire hready = hreadyout;
	int err_count = 0, n_tests = 0, g;

	// free-running 125 MHz clock
	always #4 hclk = ~hclk;

	slps_settings u_slps_settings (.*);

	// ==============================
	// helper tasks
	task automatic print_verdict;
		if (err_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// bounded wait for hready; a hang fails the run
	task automatic rdy;
		int n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_count++;
			print_verdict;
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
		rdy;
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		rdy;
		v = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(v, e);
	endtask
	task automatic dst(input slps_id_type id, input logic e);
		rx_dest_id <= id; rx_dest_valid <= 1'b1; cyc(1); rx_dest_valid <= 1'b0; cyc(1);
		chk({rx_dest_checked, rx_dest_accept}, {1'b1, e});
	endtask
	task automatic rsp(input slps_prio_type p, a, input logic c, input slps_prio_type ep, input logic ec);
		req_prio <= p; rsp_auto_prio <= a; req_crf <= c; rsp_valid <= 1'b1; cyc(1);
		rsp_valid <= 1'b0; cyc(1);
		chk({rsp_out_valid, rsp_prio, rsp_crf}, {1'b1, ep, ec});
	endtask
	task automatic ctx(input logic [3:0] n, input slps_prio_type p, input logic e);
		ctx_free_count <= n; ctx_req_prio <= p; cyc(2);
		chk(ctx_alloc_ok, e);
	endtask

	// ==============================
	// main sequence; reset held for two cycles
	initial begin
		cyc(2);
		hresetn <= 1'b1;
		cyc(1);
		chk({memory_access_swap_bytes, load_store_swap_bytes, tx_rx_unit_swap_bytes}, 12'h111);
		chk({bus_priority, hresp}, 4'h8);
		rdc(8'h14, 32'h00053800);
		rdc(8'h18, 32'h0);
		rdc(8'h24, 32'h7FF);
		rdc(8'h30, 32'h0);
		wr(8'h14, 32'hFEFFFFFF);
		rdc(8'h14, 32'hF8FFFEFF);
		chk({lane_tx_enable, lane_rx_enable}, 8'hFF);
		for (int c = 0; c < 4; c++) begin
			wr(8'h18, c << 2); cyc(2);
			chk({bus_clock_as_core_clock, core_clock_lane_select}, 3'(c));
		end
		wr(8'h18, 32'hFFFFFFFF);
		rdc(8'h18, 32'h0000F3FF);
		cyc(1);
		chk({bus_clock_as_core_clock, core_clock_lane_select, lane_loopback}, 7'h7F);
		ctx(4'h2, 2'h0, 1'b0);
		ctx(4'h2, 2'h1, 1'b1);
		ctx(4'h1, 2'h1, 1'b0);
		ctx(4'h1, 2'h2, 1'b1);
		ctx(4'h3, 2'h0, 1'b1);
		rx_cos <= 8'hA5; cyc(2);
		chk(rx_context_cos, 8'hA5);
		rsp(2'h1, 2'h0, 1'b0, 2'h2, 1'b1);
		wr(8'h18, 32'h0); cyc(2);
		chk(rx_context_cos, 8'h0);
		ctx(4'h1, 2'h0, 1'b1);
		rsp(2'h3, 2'h1, 1'b0, 2'h3, 1'b0);
		wr(8'h14, 32'h0);
		rsp(2'h0, 2'h2, 1'b1, 2'h2, 1'b1);
		phy_lane_tx_enable <= 4'h5; phy_lane_rx_enable <= 4'hA; cyc(2);
		chk({lane_tx_enable, lane_rx_enable}, 8'h5A);
		// every swap code, bus priority alongside
		for (int c = 0; c < 4; c++) begin
			wr(8'h14, (c << 30) | (c << 28) | (c << 22) | (c << 9)); cyc(2);
			chk({memory_access_swap_bytes, load_store_swap_bytes, tx_rx_unit_swap_bytes},
				{3{4'(1 << c)}});
			chk(bus_priority, 3'(c));
		end
		// each threshold code below and at its count
		for (int c = 0; c < 8; c++) begin
			wr(8'h14, (c << 18) | (c << 15) | (c << 12));
			for (int p = 0; p < 3; p++) begin
				tx_pkt_prio <= 2'(p); tx_free_buffers <= 4'(c); cyc(2);
				chk(tx_send_allowed, 1'b0);
				tx_free_buffers <= 4'(c + 1); cyc(2);
				chk(tx_send_allowed, 1'b1);
			end
		end
		// discard after exactly 2^code expiries; reserved codes count 32
		for (int c = 0; c < 8; c++) begin
			wr(8'h18, c << 12);
			retry_start <= 1'b1; cyc(1); retry_start <= 1'b0;
			retry_timer_expired <= 1'b1; cyc(c < 6 ? 1 << c : 32); retry_timer_expired <= 1'b0;
			chk(retry_discard, 1'b0);
			cyc(1);
			chk(retry_discard, 1'b1);
		end
		// tick spacing at both reload ends, after stale ticks drain
		for (int r = 0; r < 16; r += 15) begin
			wr(8'h14, r << 4);
			cyc(2);
			g = 0;
			while (timer_tick !== 1'b1 && g < 40) begin cyc(1); g++; end
			g = 0;
			do begin cyc(1); g++; end while (timer_tick !== 1'b1 && g < 40);
			chk(g, r + 1);
		end
		wr(8'h14, 32'h0);
		dst(16'h0042, 1'b1);
		dst(16'h0777, 1'b1);
		dst(16'hFFFF, 1'b1);
		dst(16'h0123, 1'b0);
		wr(8'h14, 32'h08000000);
		dst(16'h0123, 1'b1);
		wr(8'h20, 32'h0); cyc(2);
		chk({peripheral_reset_n, block_reset_n}, 11'h0);
		rdc(8'h24, 32'h0);
		wr(8'h20, 32'h1);
		wr(8'h4C, 32'h0); cyc(2);
		chk(block_reset_n, 10'h3F7);
		rdc(8'h8C, 32'h0);
		rdc(8'h24, 32'h7EF);
		// boot-done locks the ID and starts bring-up once
		wr(8'h1C, 32'h1234);
		rdc(8'h1C, 32'h1234);
		wr(8'h14, 32'h01000000);
		g = 0;
		while (phy_init_start !== 1'b1 && g < 8) begin cyc(1); g++; end
		chk({phy_init_start, phy_init_enable}, 2'h3);
		wr(8'h1C, 32'h5678);
		rdc(8'h1C, 32'h1234);
		dst(16'h1234, 1'b1);
		wr(8'h14, 32'h0);
		rdc(8'h14, 32'h01000000);
		print_verdict;
	end
endmodule // tb
`default_nettype wire
